// >>> hw/amc_aux_channels.sv
// Auxiliary link master for the repeating channel 3 and one-shot channel 4
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module amc_aux_channels
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire amc_pkg::amc_apb_req_type i_apb,
	output var amc_pkg::amc_apb_rsp_type o_apb,
	input wire logic i_sample_tick,
	input wire logic i_low_busy,
	input wire logic i_scl,
	output logic o_scl_o,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	output logic o_irq
);

	amc_pkg::amc_state_type s_reg;
	amc_pkg::amc_state_type s_next;

	always_comb
	begin
		logic [7:0] idx;
		logic [7:0] sidx;
		logic [7:0] wbyte;
		logic [7:0] set_bits;
		logic [7:0] clr_bits;
		logic [7:0] gate;
		logic qend;
		logic bend;
		logic rx;
		logic pair_start;
		logic more;
		logic commit;
		s_next = s_reg;
		idx = i_apb.paddr[9:2];
		sidx = idx - amc_pkg::IDX_STORE_BASE;
		set_bits = amc_pkg::REG_RESET;
		clr_bits = amc_pkg::REG_RESET;
		s_next.line_level = 1'b0;
		wbyte = s_reg.ctx_ch4 ? s_reg.ch4_wr : s_reg.ch3_wr;
		rx = (s_reg.phase == amc_pkg::PH_DATA) && s_reg.ctx_rnw;
		more = ({1'b0, s_reg.cnt} + 5'h01) < {1'b0, s_reg.ctx_len};
		pair_start = ((s_reg.ctx_reg[0] ^ s_reg.cnt[0]) == s_reg.ctx_grp);

		// Pin synchronisers
		s_next.scl_s1 = i_scl;
		s_next.scl_s2 = s_reg.scl_s1;
		s_next.sda_s1 = i_sda;
		s_next.sda_s2 = s_reg.sda_s1;

		// Sample period bookkeeping
		if (i_sample_tick)
		begin
			if (s_reg.period_cnt >= s_reg.ch4_ctrl[4:0])
				s_next.period_cnt = 5'h00;
			else
				s_next.period_cnt = s_reg.period_cnt + 5'h01;
			if (s_reg.ch3_ctrl[amc_pkg::CTRL_EN_BIT] &&
				s_reg.ch3_ctrl[3:0] != 4'h0 &&
				(!s_reg.rate_sel[amc_pkg::SEL_CH3_BIT] ||
				s_reg.period_cnt == 5'h00))
				s_next.ch3_due = 1'b1;
			if (s_reg.ch4_ctrl[amc_pkg::CTRL_EN_BIT] &&
				(!s_reg.rate_sel[amc_pkg::SEL_CH4_BIT] ||
				s_reg.period_cnt == 5'h00))
				s_next.ch4_due = 1'b1;
		end

		// Quarter-bit timing with clock stretching while SCL is released
		qend = 1'b0;
		if (s_reg.fsm != amc_pkg::FSM_IDLE)
		begin
			if (s_reg.quarter == 2'h1 && !s_reg.scl_oe && !s_reg.scl_s2)
				s_next.qcnt = 8'h00;
			else if (s_reg.qcnt == amc_pkg::QUARTER_LAST)
			begin
				s_next.qcnt = 8'h00;
				s_next.quarter = s_reg.quarter + 2'h1;
				qend = 1'b1;
			end
			else
				s_next.qcnt = s_reg.qcnt + 8'h01;
		end
		bend = qend && s_reg.quarter == 2'h3;

		unique case (s_reg.fsm)
			amc_pkg::FSM_IDLE:
			begin
				s_next.qcnt = 8'h00;
				s_next.quarter = 2'h0;
				s_next.cnt = 4'h0;
				s_next.pend = 1'b0;
				if (s_reg.ch3_due && !i_low_busy)
				begin
					if (s_reg.ch3_ctrl[amc_pkg::CTRL_EN_BIT] &&
						s_reg.ch3_ctrl[3:0] != 4'h0)
					begin
						s_next.fsm = amc_pkg::FSM_START;
						s_next.ctx_ch4 = 1'b0;
						s_next.ctx_rnw = s_reg.ch3_addr[amc_pkg::ADDR_RNW_BIT];
						s_next.ctx_addr = s_reg.ch3_addr[6:0];
						s_next.ctx_reg = s_reg.ch3_reg;
						s_next.ctx_skip = s_reg.ch3_ctrl[amc_pkg::CTRL_SKIP_BIT];
						s_next.ctx_swap = s_reg.ch3_ctrl[amc_pkg::CTRL_SWAP_BIT];
						s_next.ctx_grp = s_reg.ch3_ctrl[amc_pkg::CTRL_GRP_BIT];
						s_next.ctx_len = s_reg.ch3_ctrl[3:0];
					end
					else
						s_next.ch3_due = 1'b0;
				end
				else if (s_reg.ch4_due && !s_reg.ch3_due && !i_low_busy)
				begin
					if (s_reg.ch4_ctrl[amc_pkg::CTRL_EN_BIT])
					begin
						s_next.fsm = amc_pkg::FSM_START;
						s_next.ctx_ch4 = 1'b1;
						s_next.ctx_rnw = s_reg.ch4_addr[amc_pkg::ADDR_RNW_BIT];
						s_next.ctx_addr = s_reg.ch4_addr[6:0];
						s_next.ctx_reg = s_reg.ch4_reg;
						s_next.ctx_skip = s_reg.ch4_ctrl[amc_pkg::CTRL_SKIP_BIT];
						s_next.ctx_swap = 1'b0;
						s_next.ctx_grp = 1'b0;
						s_next.ctx_len = amc_pkg::CH4_LEN;
					end
					else
						s_next.ch4_due = 1'b0;
				end
				// Skip with read goes straight to the read address
				if (s_next.fsm == amc_pkg::FSM_START)
					s_next.phase = (s_next.ctx_skip && s_next.ctx_rnw) ?
						amc_pkg::PH_ADDR_R : amc_pkg::PH_ADDR_W;
			end
			amc_pkg::FSM_START:
			begin
				// Also serves as repeated start with SCL held low
				unique case (s_reg.quarter)
					2'h0: s_next.sda_oe = 1'b0;
					2'h1: s_next.scl_oe = 1'b0;
					2'h2: s_next.sda_oe = 1'b1;
					2'h3: s_next.scl_oe = 1'b1;
				endcase
				if (bend)
				begin
					s_next.fsm = amc_pkg::FSM_BYTE;
					s_next.bitn = 4'h0;
					s_next.shift = {s_reg.ctx_addr,
						s_reg.phase == amc_pkg::PH_ADDR_R};
				end
			end
			amc_pkg::FSM_BYTE:
			begin
				unique case (s_reg.quarter)
					2'h0:
						if (s_reg.bitn == amc_pkg::ACK_BIT)
							s_next.sda_oe = rx && more;
						else
							s_next.sda_oe = !rx && !s_reg.shift[7];
					2'h1: s_next.scl_oe = 1'b0;
					2'h2:
						// Keep a received byte intact over its ack bit
						if (qend && !(rx && s_reg.bitn == amc_pkg::ACK_BIT))
							s_next.shift = {s_reg.shift[6:0], s_reg.sda_s2};
					2'h3: s_next.scl_oe = 1'b1;
				endcase
				if (bend && s_reg.bitn != amc_pkg::ACK_BIT)
					s_next.bitn = s_reg.bitn + 4'h1;
				else if (bend && !rx && s_reg.shift[0])
				begin
					// Target refused the byte
					s_next.fsm = amc_pkg::FSM_STOP;
					if (s_reg.ctx_ch4)
						set_bits[amc_pkg::ST_CH4_NACK] = 1'b1;
					else
						set_bits[amc_pkg::ST_CH3_NACK] = 1'b1;
				end
				else if (bend)
				begin
					s_next.bitn = 4'h0;
					unique case (s_reg.phase)
						amc_pkg::PH_ADDR_W:
						begin
							s_next.phase = s_reg.ctx_skip ?
								amc_pkg::PH_DATA : amc_pkg::PH_REG;
							s_next.shift = s_reg.ctx_skip ? wbyte : s_reg.ctx_reg;
						end
						amc_pkg::PH_REG:
						begin
							if (s_reg.ctx_rnw)
							begin
								s_next.phase = amc_pkg::PH_ADDR_R;
								s_next.fsm = amc_pkg::FSM_START;
							end
							else
							begin
								s_next.phase = amc_pkg::PH_DATA;
								s_next.shift = wbyte;
							end
						end
						amc_pkg::PH_ADDR_R:
							s_next.phase = amc_pkg::PH_DATA;
						amc_pkg::PH_DATA:
						begin
							s_next.cnt = s_reg.cnt + 4'h1;
							s_next.shift = wbyte;
							if (!more)
								s_next.fsm = amc_pkg::FSM_STOP;
							if (rx && s_reg.ctx_ch4)
								s_next.ch4_rd = s_reg.shift;
							else if (rx)
							begin
								s_next.store[s_reg.cnt] = s_reg.shift;
								if (s_reg.pend)
								begin
									s_next.store[4'(s_reg.cnt - 4'h1)] =
										s_reg.shift;
									s_next.store[s_reg.cnt] = s_reg.pend_byte;
									s_next.pend = 1'b0;
								end
								else if (s_reg.ctx_swap && pair_start && more)
								begin
									s_next.pend = 1'b1;
									s_next.pend_byte = s_reg.shift;
								end
							end
						end
					endcase
				end
			end
			amc_pkg::FSM_STOP:
			begin
				unique case (s_reg.quarter)
					2'h0: s_next.sda_oe = 1'b1;
					2'h1: s_next.scl_oe = 1'b0;
					2'h2: s_next.sda_oe = 1'b0;
					2'h3: s_next.scl_oe = 1'b0;
				endcase
				if (bend)
				begin
					s_next.fsm = amc_pkg::FSM_IDLE;
					if (s_reg.ctx_ch4)
					begin
						set_bits[amc_pkg::ST_CH4_DONE] = 1'b1;
						s_next.ch4_ctrl[amc_pkg::CTRL_EN_BIT] = 1'b0;
						s_next.ch4_due = 1'b0;
					end
					else
						s_next.ch3_due = 1'b0;
				end
			end
		endcase

		// APB slave: one wait state, write takes effect with pready
		commit = i_apb.psel && i_apb.penable && s_reg.apb.pready;
		s_next.apb.pready = i_apb.psel && i_apb.penable && !s_reg.apb.pready;
		if (s_next.apb.pready)
		begin
			s_next.apb.pslverr = 1'b0;
			s_next.apb.prdata = 32'h0000_0000;
			unique case (idx)
				amc_pkg::IDX_CH3_ADDR: s_next.apb.prdata[7:0] = s_reg.ch3_addr;
				amc_pkg::IDX_CH3_REG: s_next.apb.prdata[7:0] = s_reg.ch3_reg;
				amc_pkg::IDX_CH3_CTRL: s_next.apb.prdata[7:0] = s_reg.ch3_ctrl;
				amc_pkg::IDX_CH3_WDATA: s_next.apb.prdata[7:0] = s_reg.ch3_wr;
				amc_pkg::IDX_CH4_ADDR: s_next.apb.prdata[7:0] = s_reg.ch4_addr;
				amc_pkg::IDX_CH4_REG: s_next.apb.prdata[7:0] = s_reg.ch4_reg;
				amc_pkg::IDX_CH4_WDATA: s_next.apb.prdata[7:0] = s_reg.ch4_wr;
				amc_pkg::IDX_CH4_CTRL: s_next.apb.prdata[7:0] = s_reg.ch4_ctrl;
				amc_pkg::IDX_CH4_RDATA: s_next.apb.prdata[7:0] = s_reg.ch4_rd;
				amc_pkg::IDX_STATUS: s_next.apb.prdata[7:0] = s_reg.status;
				amc_pkg::IDX_MASK: s_next.apb.prdata[7:0] = s_reg.mask;
				amc_pkg::IDX_RATE_SEL: s_next.apb.prdata[7:0] = s_reg.rate_sel;
				default:
					if (idx >= amc_pkg::IDX_STORE_BASE &&
						sidx < amc_pkg::STORE_DEPTH)
						s_next.apb.prdata[7:0] = s_reg.store[sidx[3:0]];
					else
						s_next.apb.pslverr = 1'b1;
			endcase
		end
		else
		begin
			s_next.apb.pslverr = 1'b0;
			s_next.apb.prdata = 32'h0000_0000;
		end
		if (commit && i_apb.pwrite)
		begin
			unique case (idx)
				amc_pkg::IDX_CH3_ADDR: s_next.ch3_addr = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH3_REG: s_next.ch3_reg = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH3_CTRL: s_next.ch3_ctrl = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH3_WDATA: s_next.ch3_wr = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH4_ADDR: s_next.ch4_addr = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH4_REG: s_next.ch4_reg = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH4_WDATA: s_next.ch4_wr = i_apb.pwdata[7:0];
				amc_pkg::IDX_CH4_CTRL: s_next.ch4_ctrl = i_apb.pwdata[7:0];
				amc_pkg::IDX_STATUS: clr_bits = i_apb.pwdata[7:0];
				amc_pkg::IDX_MASK: s_next.mask = i_apb.pwdata[7:0];
				amc_pkg::IDX_RATE_SEL: s_next.rate_sel = i_apb.pwdata[7:0];
				default: ;
			endcase
		end

		// Sticky status, a new event beats a clear in the same cycle
		s_next.status = (s_reg.status & ~clr_bits) | set_bits;
		gate = 8'hff;
		gate[amc_pkg::ST_CH4_DONE] = s_next.ch4_ctrl[amc_pkg::CTRL_IRQEN_BIT];
		s_next.irq = |(s_next.status & s_next.mask & gate);

		if (i_rst)
		begin
			s_next = '0;
			s_next.fsm = amc_pkg::FSM_IDLE;
			s_next.phase = amc_pkg::PH_ADDR_W;
			s_next.scl_s1 = 1'b1;
			s_next.scl_s2 = 1'b1;
			s_next.sda_s1 = 1'b1;
			s_next.sda_s2 = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		s_reg <= s_next;
	end

	assign o_apb = s_reg.apb;
	assign o_scl_o = s_reg.line_level;
	assign o_scl_oe = s_reg.scl_oe;
	assign o_sda_o = s_reg.line_level;
	assign o_sda_oe = s_reg.sda_oe;
	assign o_irq = s_reg.irq;

endmodule
`default_nettype wire

// >>> hw/amc_pkg.sv
// Constants, register map and carrier types of the auxiliary channel block
package amc_pkg;
	// Bus timing of the auxiliary link
	localparam int CLK_PERIOD_NS = 4;
	localparam int QUARTER_NS = 625;
	localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CH3_ADDR = 8'h2e;
	localparam logic [7:0] IDX_CH3_REG = 8'h2f;
	localparam logic [7:0] IDX_CH3_CTRL = 8'h30;
	localparam logic [7:0] IDX_CH4_ADDR = 8'h31;
	localparam logic [7:0] IDX_CH4_REG = 8'h32;
	localparam logic [7:0] IDX_CH4_WDATA = 8'h33;
	localparam logic [7:0] IDX_CH4_CTRL = 8'h34;
	localparam logic [7:0] IDX_CH4_RDATA = 8'h35;
	localparam logic [7:0] IDX_STATUS = 8'h36;
	localparam logic [7:0] IDX_MASK = 8'h38;
	localparam logic [7:0] IDX_STORE_BASE = 8'h49;
	localparam logic [7:0] IDX_CH3_WDATA = 8'h66;
	localparam logic [7:0] IDX_RATE_SEL = 8'h67;
	localparam logic [7:0] STORE_DEPTH = 8'h10;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Field positions
	localparam int ADDR_RNW_BIT = 7;
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_SWAP_BIT = 6;
	localparam int CTRL_IRQEN_BIT = 6;
	localparam int CTRL_SKIP_BIT = 5;
	localparam int CTRL_GRP_BIT = 4;
	localparam int ST_CH4_DONE = 6;
	localparam int ST_CH4_NACK = 4;
	localparam int ST_CH3_NACK = 3;
	localparam int SEL_CH3_BIT = 3;
	localparam int SEL_CH4_BIT = 4;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] CH4_LEN = 4'h1;

	typedef enum {FSM_IDLE, FSM_START, FSM_BYTE, FSM_STOP} amc_fsm_type;
	typedef enum {PH_ADDR_W, PH_REG, PH_ADDR_R, PH_DATA} amc_phase_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} amc_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} amc_apb_rsp_type;

	typedef struct packed {
		logic [7:0] ch3_addr;
		logic [7:0] ch3_reg;
		logic [7:0] ch3_ctrl;
		logic [7:0] ch3_wr;
		logic [7:0] ch4_addr;
		logic [7:0] ch4_reg;
		logic [7:0] ch4_wr;
		logic [7:0] ch4_ctrl;
		logic [7:0] ch4_rd;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] rate_sel;
		logic [15:0][7:0] store;
		amc_apb_rsp_type apb;
		amc_fsm_type fsm;
		amc_phase_type phase;
		logic [7:0] qcnt;
		logic [1:0] quarter;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic pend;
		logic [7:0] pend_byte;
		logic ctx_ch4;
		logic ctx_rnw;
		logic ctx_skip;
		logic ctx_swap;
		logic ctx_grp;
		logic [6:0] ctx_addr;
		logic [7:0] ctx_reg;
		logic [3:0] ctx_len;
		logic ch3_due;
		logic ch4_due;
		logic [4:0] period_cnt;
		logic scl_oe;
		logic sda_oe;
		logic line_level;
		logic scl_s1;
		logic scl_s2;
		logic sda_s1;
		logic sda_s2;
		logic irq;
	} amc_state_type;
endpackage

// >>> tb/amc_aux_channels_tb_top.sv
// Self-checking bench for the auxiliary channel block
`timescale 1ns/10ps
`default_nettype none
module amc_aux_channels_tb_top;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic tick = 1'b0;
	logic busy = 1'b0;
	logic scl_oe, sda_oe, tgt_oe, irq;
	logic [7:0] tgt_byte = 8'h00;
	amc_pkg::amc_apb_req_type req = '0;
	amc_pkg::amc_apb_rsp_type rsp;
	wire logic scl_w = !scl_oe;
	wire logic sda_w = !(sda_oe | tgt_oe);
	int miscompares = 0;
	int comparisons = 0;
	always #2 i_mclk = ~i_mclk;
	amc_aux_channels u_amc_aux_channels
	(
		.i_mclk(i_mclk), .i_rst(i_rst), .i_apb(req), .o_apb(rsp),
		.i_sample_tick(tick), .i_low_busy(busy), .i_scl(scl_w),
		.o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(),
		.o_sda_oe(sda_oe), .o_irq(irq)
	);
	amc_target_model u_amc_target_model
	(
		.i_scl(scl_w), .i_sda(sda_w), .i_rd_byte(tgt_byte), .o_sda_oe(tgt_oe)
	);
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x)
		begin
			miscompares++;
			$display("FAIL %0t got %h want %h", $time, s, x);
		end
	endtask
	task automatic print_verdict;
		$display("Mismatches %0d, comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		int n;
		n = 0;
		@(posedge i_mclk);
		req <= '{1'b1, 1'b0, w, {22'h0, a, 2'h0}, {24'h0, d}};
		@(posedge i_mclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge i_mclk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1)
		begin
			miscompares++;
			$display("FAIL %0t bus answer missing", $time);
		end
		r = rsp.prdata[7:0];
		e = rsp.pslverr;
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		logic [7:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		check({23'h0, e, r}, {24'h0, x});
	endtask
	task automatic pulse;
		@(posedge i_mclk);
		tick <= 1'b1;
		@(posedge i_mclk);
		tick <= 1'b0;
	endtask
	task automatic quiet(input int c);
		logic act;
		act = 1'b0;
		repeat (c)
		begin
			@(negedge i_mclk);
			act = act | scl_oe | sda_oe;
		end
		check({31'h0, act}, 32'h0);
	endtask
	task automatic t_regs;
		logic [7:0] r;
		logic e;
		wr(amc_pkg::IDX_CH3_ADDR, 8'hd5);
		wr(amc_pkg::IDX_CH3_REG, 8'h3b);
		wr(amc_pkg::IDX_CH3_CTRL, 8'hf0);
		rchk(amc_pkg::IDX_CH3_ADDR, 8'hd5);
		rchk(amc_pkg::IDX_CH3_REG, 8'h3b);
		rchk(amc_pkg::IDX_CH3_CTRL, 8'hf0);
		wr(amc_pkg::IDX_CH4_RDATA, 8'h77);
		rchk(amc_pkg::IDX_CH4_RDATA, 8'h00);
		apb(1'b0, 8'h3f, 8'h00, r, e);
		check({23'h0, e, r}, 32'h100);
		pulse;
		quiet(400);
	endtask
	task automatic t_write;
		int n;
		wr(amc_pkg::IDX_CH4_ADDR, 8'h52);
		wr(amc_pkg::IDX_CH4_REG, 8'h1a);
		wr(amc_pkg::IDX_CH4_WDATA, 8'ha5);
		wr(amc_pkg::IDX_MASK, 8'h40);
		wr(amc_pkg::IDX_CH4_CTRL, 8'hc0);
		busy <= 1'b1;
		pulse;
		quiet(300);
		@(posedge i_mclk);
		busy <= 1'b0;
		n = 0;
		while (irq !== 1'b1 && n < 30000)
		begin
			@(negedge i_mclk);
			n++;
		end
		check({31'h0, irq}, 32'h1);
		check(u_amc_target_model.n, 32'h3);
		check({24'h0, u_amc_target_model.got[0]}, {24'h0, 7'h52, 1'b0});
		check({24'h0, u_amc_target_model.got[1]}, 32'h1a);
		check({24'h0, u_amc_target_model.got[2]}, 32'ha5);
		rchk(amc_pkg::IDX_STATUS, 8'h40);
		rchk(amc_pkg::IDX_CH4_CTRL, 8'h40);
		wr(amc_pkg::IDX_STATUS, 8'hff);
		rchk(amc_pkg::IDX_STATUS, 8'h00);
		@(negedge i_mclk);
		check({31'h0, irq}, 32'h0);
		pulse;
		quiet(400);
	endtask
	task automatic t_read;
		logic [7:0] r;
		logic e;
		int n;
		tgt_byte <= 8'h3c;
		wr(amc_pkg::IDX_CH4_WDATA, 8'hff);
		wr(amc_pkg::IDX_CH4_ADDR, 8'ha9);
		wr(amc_pkg::IDX_CH4_CTRL, 8'ha0);
		pulse;
		n = 0;
		do
		begin
			repeat (250) @(posedge i_mclk);
			apb(1'b0, amc_pkg::IDX_STATUS, 8'h00, r, e);
			n++;
		end
		while (r[6] !== 1'b1 && n < 200);
		check({24'h0, r}, 32'h40);
		rchk(amc_pkg::IDX_CH4_RDATA, 8'h3c);
		@(negedge i_mclk);
		check({31'h0, irq}, 32'h0);
		check(u_amc_target_model.n, 32'h4);
		check({24'h0, u_amc_target_model.got[3]}, {24'h0, 7'h29, 1'b1});
	endtask
	initial
	begin
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_regs;
		t_write;
		t_read;
		print_verdict;
	end
	initial
	begin
		repeat (90000) @(posedge i_mclk);
		miscompares++;
		print_verdict;
	end
endmodule
`default_nettype wire

// >>> tb/amc_props.sv
// Port-level checks for the auxiliary channel block
`timescale 1ns/10ps
`default_nettype none
module amc_props
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire amc_pkg::amc_apb_req_type i_apb,
	input wire amc_pkg::amc_apb_rsp_type o_apb,
	input wire logic i_sample_tick,
	input wire logic i_low_busy,
	input wire logic i_scl,
	input wire logic o_scl_o,
	input wire logic o_scl_oe,
	input wire logic i_sda,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	input wire logic o_irq
);
	localparam int QWAIT = 160;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	a_pready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
		else $error("ready held too long");
	a_wait_state: assert property
		(i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
		else $error("ready not one cycle after access");
	a_setup_quiet: assert property
		(i_apb.psel && !i_apb.penable |-> !o_apb.pready)
		else $error("ready during setup");
	a_bad_index: assert property (o_apb.pready && i_apb.paddr[9:2] == 8'h3f
		|-> o_apb.pslverr && o_apb.prdata == 32'h0)
		else $error("unmapped access not refused");
	a_open_drain: assert property (o_scl_o == 1'b0 && o_sda_o == 1'b0)
		else $error("line driven high");
	a_start_seq: assert property ($rose(o_sda_oe) && !o_scl_oe
		|-> ##[1:QWAIT] o_scl_oe)
		else $error("clock not pulled after start");
	a_stop_idle: assert property ($fell(o_sda_oe) && !o_scl_oe
		|=> (!o_scl_oe && !o_sda_oe) [*8])
		else $error("bus not idle after stop");
	a_irq_quiet: assert property ($rose(o_irq)
		|-> !o_scl_oe && !o_sda_oe)
		else $error("interrupt before stop");
	a_irq_clear: assert property (o_apb.pready && i_apb.pwrite
		&& i_apb.paddr[9:2] == amc_pkg::IDX_STATUS
		&& i_apb.pwdata[7:0] == 8'hff |-> ##2 !o_irq)
		else $error("interrupt not cleared");
endmodule
bind amc_aux_channels amc_props u_amc_props
(
	.i_mclk, .i_rst, .i_apb, .o_apb, .i_sample_tick, .i_low_busy, .i_scl,
	.o_scl_o, .o_scl_oe, .i_sda, .o_sda_o, .o_sda_oe, .o_irq
);
`default_nettype wire

// >>> tb/amc_target_model.sv
// Behavioural target on the auxiliary link: acks writes, answers reads
`timescale 1ns/10ps
`default_nettype none
module amc_target_model
(
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [7:0] i_rd_byte,
	output var logic o_sda_oe
);
	logic [7:0] got [0:7];
	logic [7:0] sh;
	int n = 0;
	int bitc = 0;
	logic rd = 1'b0;
	logic first = 1'b0;
	initial o_sda_oe = 1'b0;
	always @(negedge i_sda)
		if (i_scl === 1'b1)
		begin
			bitc = 0;
			first = 1'b1;
			rd = 1'b0;
		end
	always @(posedge i_sda)
		if (i_scl === 1'b1)
			rd = 1'b0;
	always @(posedge i_scl)
	begin
		sh = {sh[6:0], i_sda};
		bitc++;
	end
	always @(negedge i_scl)
	begin
		if (bitc == 9)
			bitc = 0;
		if (bitc == 8 && !rd)
		begin
			got[n % 8] = sh;
			n++;
			o_sda_oe = 1'b1;
			if (first)
				rd = sh[0];
			first = 1'b0;
		end
		else if (bitc == 8 || !rd)
			o_sda_oe = 1'b0;
		else
			o_sda_oe = !i_rd_byte[7 - bitc];
	end
endmodule
`default_nettype wire
